// [src/state_status_defs.vh]
`ifndef STATE_STATUS_DEFS_VH
`define STATE_STATUS_DEFS_VH

// Register byte offsets.
`define OFS_INT_STATUS 12'h010
`define OFS_INT_MASK 12'h014
`define OFS_GO_CMD 12'h120
`define OFS_XFER_REPORT 12'h128
`define OFS_REPORT_BASE 12'h800
`define OFS_REQUEST_BASE 12'ha00

// Module numbering.
`define NUM_MODULES 35
`define DSP_MODULE 6'h21
`define LAST_MODULE 6'h22

// Status field positions.
`define ST_EMU_STATE 17
`define ST_EMU_RESET 16
`define ST_CLK_RUN 12
`define ST_RSVD_ONE 11
`define ST_RST_REL 10
`define ST_LOCAL_RESET_CONTROL_DONE 9
`define ST_LOCAL_RESET_CONTROL 8

// Request field positions and reset values.
`define RQ_STATE_IE 10
`define RQ_RESET_IE 9
`define RQ_LOCAL_RESET_CONTROL 8
`define RQ_LOCAL_RESET_CONTROL_RST 1'b1
`define RQ_NEXT_RST 3'h0

// Module states.
`define MS_SWRST_DIS 6'h00
`define MS_SYNC_RST 6'h01
`define MS_DISABLE 6'h02
`define MS_ENABLE 6'h03
`define MS_MOVING 6'h04

// Interrupt status bits.
`define IRQ_EMU_STATE 0
`define IRQ_EMU_RESET 1
`define IRQ_XFER_DONE 2

`endif

// [src/module_state_status_control.v]
// Behaviour
// RL1 - Read-only status register per module 0-34.
// RL2 - Bit 17 flags emulation state override, DSP.
// RL3 - State override interrupt needs its enable set.
// RL4 - Bit 16 flags emulation reset override, DSP.
// RL5 - Reset override interrupt needs its enable set.
// RL6 - Bit 12 shows module clock running.
// RL7 - Bit 10 shows module reset released.
// RL8 - Bit 9 local reset done; others read one.
// RL9 - Software checks done before DSP access.
// RL10 - Bit 8 shows DSP local reset state.
// RL11 - Six-bit state field, 4h upward means moving.
// RL12 - Control register per module with documented fields.
// RL13 - Go command moves mismatching modules to requested.
// RL14 - Transition status high while modules move.
// RL15 - Software keeps local reset at one elsewhere.
// RL16 - Status writes ignored, bit 11 reads one.
//
// Implementation choices: the placing of the registers and register access over APB.
`timescale 1ns/100ps
`include "state_status_defs.vh"

module module_state_status_control (
  // Clock and reset.
  input wire pclk,
  input wire presetn,
  // APB slave.
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Pins from the DSP emulation logic.
  input wire emu_state_override_in,
  input wire emu_reset_override_in,
  input wire dsp_local_reset_done_in,
  // Module controls.
  output reg [34:0] module_clock_en,
  output reg [34:0] module_reset_n,
  output reg dsp_local_reset_n,
  // Interrupt.
  output reg power_controller_irq
);

  // Sequencer states.
  localparam SEQ_IDLE = 2'd0;
  localparam SEQ_SCAN = 2'd1;
  localparam SEQ_MOVE = 2'd2;

  // Per-module state and request fields.
  reg [5:0] state_r [0:34];
  reg [2:0] next_r [0:34];
  reg [34:0] local_reset_control_r;
  // Interrupt enables, kept for the DSP module only.
  reg state_ie_r;
  reg reset_ie_r;
  // Sticky status, its mask and the low three read data bits of the last setup, whatever its address.
  reg [2:0] int_status_r;
  reg [2:0] int_mask_r;
  reg [2:0] int_shown_r;
  // Sequencer position and a go command waiting to start.
  reg [1:0] seq_r;
  reg [5:0] idx_r;
  reg go_pend_r;
  // Settled pin levels: bit 0 state override, bit 1 reset override, bit 2 local reset done.
  wire [2:0] pin_lvl;
  wire [1:0] pin_rise;
  // Read data and error for the access being set up.
  reg [31:0] rd_nxt;
  reg err_nxt;
  // Loop counters, one per process so that no variable has two drivers.
  integer i_ctl;
  integer i_seq;
  integer i_out;

  // Bus phase decode.
  wire setup = psel & ~penable & ~pready;
  wire access = psel & penable & pready;
  wire wr_go = access & pwrite;
  wire in_report = (paddr >= `OFS_REPORT_BASE) && (paddr < `OFS_REPORT_BASE + 12'h08c) && (paddr[1:0] == 2'b00);
  wire in_request = (paddr >= `OFS_REQUEST_BASE) && (paddr < `OFS_REQUEST_BASE + 12'h08c) && (paddr[1:0] == 2'b00);
  // Module index of the addressed register in each bank.
  wire [11:0] rep_ofs = paddr - `OFS_REPORT_BASE;
  wire [11:0] req_ofs = paddr - `OFS_REQUEST_BASE;
  wire [5:0] rep_idx = rep_ofs[7:2];
  wire [5:0] req_idx = req_ofs[7:2];
  wire [5:0] cur_state = state_r[idx_r];
  wire [5:0] cur_next = {3'h0, next_r[idx_r]};
  wire xfer_done = (seq_r == SEQ_SCAN) && (idx_r == `LAST_MODULE) && (cur_state == cur_next);
  wire int_read = access & ~pwrite & (paddr == `OFS_INT_STATUS);
  // Write strobes, each taken at the access edge.
  wire wr_request = wr_go & in_request;
  wire wr_mask = wr_go & (paddr == `OFS_INT_MASK);
  wire wr_start = wr_go & (paddr == `OFS_GO_CMD) & pwdata[0];
  // Events that become sticky; the two override events are gated by the DSP control enables, transfer done is not.
  wire [2:0] int_set = {xfer_done, pin_rise[1] & reset_ie_r, pin_rise[0] & state_ie_r}; // RL3 RL5

  // Build the status word of one module.
  function [31:0] report_word;
    input [5:0] n;
    input [5:0] st;
    input local_reset_control;
    input clk_on;
    input rst_rel;
    input [2:0] pins;
    reg dsp;
    begin
      dsp = (n == `DSP_MODULE);
      report_word = 32'h0000_0000;
      report_word[`ST_EMU_STATE] = dsp & pins[0]; // RL2
      report_word[`ST_EMU_RESET] = dsp & pins[1]; // RL4
      report_word[`ST_CLK_RUN] = clk_on; // RL6
      report_word[`ST_RSVD_ONE] = 1'b1; // RL16
      report_word[`ST_RST_REL] = rst_rel; // RL7
      report_word[`ST_LOCAL_RESET_CONTROL_DONE] = dsp ? pins[2] : 1'b1; // RL8
      report_word[`ST_LOCAL_RESET_CONTROL] = local_reset_control; // RL10
      report_word[5:0] = st; // RL11
    end
  endfunction

  // Read data and error for the access that is being set up.
  always @* begin
    rd_nxt = 32'h0000_0000;
    err_nxt = 1'b0;
    if (in_report) begin
      rd_nxt = report_word(rep_idx, state_r[rep_idx], local_reset_control_r[rep_idx], module_clock_en[rep_idx],
                           module_reset_n[rep_idx], pin_lvl); // RL1
    end else if (in_request) begin
      rd_nxt[2:0] = next_r[req_idx]; // RL12
      rd_nxt[`RQ_LOCAL_RESET_CONTROL] = local_reset_control_r[req_idx];
      if (req_idx == `DSP_MODULE) begin
        rd_nxt[`RQ_STATE_IE] = state_ie_r;
        rd_nxt[`RQ_RESET_IE] = reset_ie_r;
      end
    end else begin
      case (paddr)
        `OFS_INT_STATUS: rd_nxt[2:0] = int_status_r;
        `OFS_INT_MASK: rd_nxt[2:0] = int_mask_r;
        `OFS_GO_CMD: rd_nxt = 32'h0000_0000;
        `OFS_XFER_REPORT: rd_nxt[0] = (seq_r != SEQ_IDLE) | go_pend_r; // RL14
        default: err_nxt = 1'b1;
      endcase
    end
  end

  // APB handshake: one wait-free access cycle after each setup.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= setup;
      if (setup) begin
        pslverr <= err_nxt;
        prdata <= pwrite ? 32'h0000_0000 : rd_nxt;
      end else begin
        pslverr <= 1'b0;
      end
    end
  end

  // Bits shown by a status read; only these are cleared, so an event that
  // lands between setup and access stays pending instead of being lost.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_shown_r <= 3'h0;
    end else if (setup) begin
      int_shown_r <= rd_nxt[2:0];
    end
  end

  // Emulation state override pin.
  pin_sync #(
    .RESET_LEVEL(1'b0)
  ) state_pin_sync (
    .pclk(pclk),
    .presetn(presetn),
    .pin_in(emu_state_override_in),
    .level(pin_lvl[0]),
    .rise(pin_rise[0])
  );

  // Emulation reset override pin.
  pin_sync #(
    .RESET_LEVEL(1'b0)
  ) reset_pin_sync (
    .pclk(pclk),
    .presetn(presetn),
    .pin_in(emu_reset_override_in),
    .level(pin_lvl[1]),
    .rise(pin_rise[1])
  );

  // DSP local reset done pin; only its level is reported.
  pin_sync #(
    .RESET_LEVEL(1'b0)
  ) done_pin_sync (
    .pclk(pclk),
    .presetn(presetn),
    .pin_in(dsp_local_reset_done_in),
    .level(pin_lvl[2]),
    .rise()
  );

  // Control registers; status offsets take no writes.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (i_ctl = 0; i_ctl < `NUM_MODULES; i_ctl = i_ctl + 1) begin
        next_r[i_ctl] <= `RQ_NEXT_RST; // RL12
      end
      local_reset_control_r <= {35{`RQ_LOCAL_RESET_CONTROL_RST}};
      state_ie_r <= 1'b0;
      reset_ie_r <= 1'b0;
      int_mask_r <= 3'h0;
    end else if (wr_request) begin // RL16
      next_r[req_idx] <= pwdata[2:0]; // RL12
      local_reset_control_r[req_idx] <= pwdata[`RQ_LOCAL_RESET_CONTROL];
      if (req_idx == `DSP_MODULE) begin
        state_ie_r <= pwdata[`RQ_STATE_IE];
        reset_ie_r <= pwdata[`RQ_RESET_IE];
      end
    end else if (wr_mask) begin
      int_mask_r <= pwdata[2:0];
    end
  end

  // Sticky interrupt bits; a new event wins over the read that clears, and
  // the read clears only the bits that it returned.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_status_r <= 3'h0;
      power_controller_irq <= 1'b0;
    end else begin
      int_status_r <= (int_status_r & ~(int_read ? int_shown_r : 3'h0)) | int_set;
      power_controller_irq <= |(int_status_r & int_mask_r);
    end
  end

  // Transition sequencer: walks all modules, moving each that differs.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seq_r <= SEQ_IDLE;
      idx_r <= 6'h00;
      go_pend_r <= 1'b0;
      for (i_seq = 0; i_seq < `NUM_MODULES; i_seq = i_seq + 1) begin
        state_r[i_seq] <= `MS_SWRST_DIS;
      end
    end else begin
      if (wr_start) begin
        go_pend_r <= 1'b1;
      end
      case (seq_r)
        SEQ_IDLE: begin
          if (go_pend_r) begin
            go_pend_r <= 1'b0;
            idx_r <= 6'h00;
            seq_r <= SEQ_SCAN;
          end
        end
        SEQ_SCAN: begin
          if (cur_state != cur_next) begin
            state_r[idx_r] <= `MS_MOVING; // RL13
            seq_r <= SEQ_MOVE;
          end else if (idx_r == `LAST_MODULE) begin
            seq_r <= SEQ_IDLE;
          end else begin
            idx_r <= idx_r + 6'h01;
          end
        end
        SEQ_MOVE: begin
          state_r[idx_r] <= cur_next; // RL13
          seq_r <= SEQ_SCAN;
        end
        default: seq_r <= SEQ_IDLE;
      endcase
    end
  end

  // Module clock and reset follow the settled states; DSP local reset follows its control bit.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      module_clock_en <= 35'h0;
      module_reset_n <= 35'h0;
      dsp_local_reset_n <= `RQ_LOCAL_RESET_CONTROL_RST;
    end else begin
      for (i_out = 0; i_out < `NUM_MODULES; i_out = i_out + 1) begin
        module_clock_en[i_out] <= (state_r[i_out] == `MS_ENABLE); // RL6
        module_reset_n[i_out] <= (state_r[i_out] == `MS_ENABLE) || (state_r[i_out] == `MS_DISABLE); // RL7
      end
      dsp_local_reset_n <= local_reset_control_r[`DSP_MODULE]; // RL10
    end
  end

endmodule

// Brings one pin into the clock domain through three stages.
module pin_sync #(
  parameter [0:0] RESET_LEVEL = 1'b0
) (
  // Clock and reset.
  input wire pclk,
  input wire presetn,
  // Raw pin.
  input wire pin_in,
  // Settled level and a one-cycle pulse on each rise of it.
  output wire level,
  output wire rise
);

  // Only the second stage reads the first, which may go metastable.
  reg meta_r;
  reg mid_r;
  reg last_r;
  // Accepted level and its value one cycle earlier.
  reg level_r;
  reg prev_r;

  // A change counts once the second and third stages agree on it.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_r <= RESET_LEVEL;
      mid_r <= RESET_LEVEL;
      last_r <= RESET_LEVEL;
      level_r <= RESET_LEVEL;
      prev_r <= RESET_LEVEL;
    end else begin
      meta_r <= pin_in;
      mid_r <= meta_r;
      last_r <= mid_r;
      if (mid_r == last_r) begin
        level_r <= last_r;
      end
      prev_r <= level_r;
    end
  end

  // The edge detector resets to the idle level, so no false rise follows reset.
  assign level = level_r;
  assign rise = level_r & ~prev_r;

endmodule

// [testbench/dsp_emu_model.sv]
`timescale 1ns/100ps
// Stand-in for the DSP emulation logic and local reset.
module dsp_emu_model #(parameter integer LAT = 3) (
  // Clock and commands.
  input wire pclk,
  input wire dsp_local_reset_n,
  input wire state_cmd,
  input wire reset_cmd,
  // Pins into the controller.
  output reg emu_state_override_in = 1'b0,
  output reg emu_reset_override_in = 1'b0,
  output wire dsp_local_reset_done_in
);
  reg [7:0] done_r = 8'h00;
  // Done rises LAT+1 cycles after release, so software must wait.
  always @(posedge pclk) begin
    done_r <= dsp_local_reset_n ? {done_r[6:0], 1'b1} : 8'h00;
    emu_state_override_in <= state_cmd;
    emu_reset_override_in <= reset_cmd;
  end
  assign dsp_local_reset_done_in = done_r[LAT];
endmodule

// [testbench/state_status_sva.sv]
`timescale 1ns/100ps
`include "state_status_defs.vh"
module state_status_sva (
  // Watched ports.
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire [34:0] module_clock_en,
  input wire [34:0] module_reset_n,
  input wire dsp_local_reset_n,
  input wire power_controller_irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Setup, status-read and write-access qualifiers.
  wire setup = psel && !penable && !pready;
  wire rd0 = setup && !pwrite && paddr == `OFS_REPORT_BASE;
  wire wr = psel && penable && pready && pwrite;
  AST_READY: assert property (setup |=> pready) else $error("no ready");
  AST_PULSE: assert property (pready |=> !pready) else $error("ready held");
  AST_ERR: assert property (pslverr |-> pready) else $error("lone error");
  AST_CLK_RST: assert property ((module_clock_en & ~module_reset_n) == 35'h0) else $error("clock in reset");
  AST_LOCAL_RESET_CONTROL: assert property (wr && paddr == 12'ha84 |-> ##2 dsp_local_reset_n == $past(pwdata[8], 2))
    else $error("local reset");
  AST_CONST: assert property (rd0 |=> prdata[31:16] == 16'h0 && prdata[11] && prdata[9]) else $error("const");
  AST_MASK: assert property (wr && paddr == `OFS_INT_MASK && pwdata[2:0] == 3'h0 |-> ##2 !power_controller_irq)
    else $error("masked irq");
  AST_CLK: assert property (rd0 |=> prdata[12] == module_clock_en[0] || prdata[12] == $past(module_clock_en[0]))
    else $error("clock bit");
endmodule
bind module_state_status_control state_status_sva sva_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .prdata, .pready, .pslverr, .module_clock_en, .module_reset_n, .dsp_local_reset_n, .power_controller_irq);

// [testbench/test_module_state_status_control.sv]
`timescale 1ns/100ps
`include "state_status_defs.vh"
module test_module_state_status_control;
  localparam [11:0] RPT = `OFS_REPORT_BASE;
  localparam [11:0] REQ = `OFS_REQUEST_BASE;
  reg pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
  reg [11:0] paddr = 12'h000;
  reg [31:0] pwdata = 32'h0, q;
  reg [1:0] emu_cmd = 2'b00;
  wire [31:0] prdata;
  wire pready, pslverr, st_in, rs_in, done_in, local_reset_control_n, irq;
  wire [34:0] clk_en, rst_n;
  integer fails = 0, samples_checked = 0, k;
  module_state_status_control dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .emu_state_override_in(st_in), .emu_reset_override_in(rs_in),
    .dsp_local_reset_done_in(done_in), .module_clock_en(clk_en), .module_reset_n(rst_n),
    .dsp_local_reset_n(local_reset_control_n), .power_controller_irq(irq));
  dsp_emu_model emu (.pclk, .dsp_local_reset_n(local_reset_control_n), .state_cmd(emu_cmd[0]), .reset_cmd(emu_cmd[1]),
    .emu_state_override_in(st_in), .emu_reset_override_in(rs_in), .dsp_local_reset_done_in(done_in));
  // Free-running bus clock.
  initial begin
    forever #2.5 pclk = ~pclk;
  end
  // Compares one value and counts it.
  task check(input [31:0] seen, input [31:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (seen !== exp) begin
        fails = fails + 1;
        $display("[FAIL] %0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask
  // Prints the counts and the verdict, then ends the run.
  task report_and_stop;
    begin
      $display("checks=%0d fails=%0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0)
        $display("*** PASS ***");
      else
        $display("*** FAIL ***");
      $finish;
    end
  endtask
  // One bus transfer; the request holds until ready is seen, then one idle cycle.
  task apb(input w, input [11:0] a, input [31:0] d);
    integer i;
    begin
      psel <= 1'b1;
      {pwrite, paddr, pwdata} <= {w, a, d};
      @(posedge pclk);
      penable <= 1'b1;
      for (i = 0; i < 20 && pready !== 1'b1; i = i + 1)
        @(posedge pclk);
      if (i == 20) begin
        fails = fails + 1;
        report_and_stop;
      end
      q = prdata;
      err = pslverr;
      {psel, penable} <= 2'b00;
      @(posedge pclk);
    end
  endtask
  // Re-reads a register until the masked bits match, within a bound.
  task poll(input [11:0] a, input [31:0] m, input [31:0] v);
    integer i;
    begin
      q = ~v;
      for (i = 0; i < 60 && (q & m) !== v; i = i + 1)
        apb(1'b0, a, 32'h0);
      if ((q & m) !== v) begin
        fails = fails + 1;
        report_and_stop;
      end
    end
  endtask
  // Reset values, ignored status write and an unmapped address.
  task test_reset;
    begin
      apb(1'b0, RPT, 32'h0);
      check(q, 32'hb00);
      apb(1'b0, REQ, 32'h0);
      check(q, 32'h100);
      apb(1'b1, RPT + 12'h084, 32'hffffffff);
      apb(1'b0, RPT + 12'h084, 32'h0);
      check(q, 32'hb00);
      apb(1'b0, 12'hffc, 32'h0);
      check({q[30:0], err}, 32'h1);
      $display("reset test done");
    end
  endtask
  // Walks module 5 through every state with the go command.
  task test_states;
    begin
      for (k = 3; k >= 0; k = k - 1) begin
        apb(1'b1, REQ + 12'h014, 32'h100 | k);
        apb(1'b1, `OFS_GO_CMD, 32'h1);
        apb(1'b0, `OFS_XFER_REPORT, 32'h0);
        check(q, 32'h1);
        poll(`OFS_XFER_REPORT, 32'h1, 32'h0);
        apb(1'b0, RPT + 12'h014, 32'h0);
        check(q, {19'h0, k == 3, 1'b1, k >= 2, 4'hc, k[5:0]});
        check({clk_en[5], rst_n[5]}, {k == 3, k >= 2});
      end
      $display("state test done");
    end
  endtask
  // DSP local reset asserted, then released with software waiting for done.
  task test_local_reset;
    begin
      apb(1'b1, REQ + 12'h084, 32'h0);
      poll(RPT + 12'h084, 32'h200, 32'h0);
      check({q[8], local_reset_control_n}, 2'b00);
      apb(1'b1, REQ + 12'h084, 32'h100);
      poll(RPT + 12'h084, 32'h200, 32'h200);
      check(q, 32'hb00);
      $display("local reset test done");
    end
  endtask
  // Raises one override pin and checks flag, sticky status and line.
  task pulse_emu(input integer b, input [31:0] ctl, input [31:0] flag, input [31:0] ist, input ie);
    begin
      apb(1'b1, REQ + 12'h084, ctl);
      emu_cmd[b] <= 1'b1;
      repeat (8) @(posedge pclk);
      check(irq, ie);
      apb(1'b0, RPT + 12'h084, 32'h0);
      check(q, 32'hb00 | flag);
      apb(1'b0, `OFS_INT_STATUS, 32'h0);
      check(q, ist);
      emu_cmd[b] <= 1'b0;
      repeat (8) @(posedge pclk);
      check(irq, 1'b0);
    end
  endtask
  // Override flags with enables off, on, and masked.
  task test_emu;
    begin
      apb(1'b1, `OFS_INT_MASK, 32'h7);
      apb(1'b0, `OFS_INT_STATUS, 32'h0);
      check(q, 32'h4);
      pulse_emu(0, 32'h100, 32'h20000, 32'h0, 1'b0);
      pulse_emu(0, 32'h500, 32'h20000, 32'h1, 1'b1);
      pulse_emu(1, 32'h100, 32'h10000, 32'h0, 1'b0);
      pulse_emu(1, 32'h300, 32'h10000, 32'h2, 1'b1);
      apb(1'b1, `OFS_INT_MASK, 32'h0);
      pulse_emu(0, 32'h500, 32'h20000, 32'h1, 1'b0);
      $display("emulation test done");
    end
  endtask
  // Main sequence.
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    test_reset;
    test_states;
    test_local_reset;
    test_emu;
    report_and_stop;
  end
endmodule
